// File: rtl/dtcs_timers.sv
`timescale 1ns/1ns
`default_nettype none


module dtcs_timers (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Mode and run controls held elsewhere in the core
  input  wire logic [7:0] timer_mode_register,
  input  wire logic       timer0_run,
  input  wire logic       timer1_run,
  // Overflow flag access
  input  wire logic [1:0] flag_wr,
  input  wire logic [1:0] flag_wdata,
  input  wire logic [1:0] isr_entry,
  output logic      [1:0] overflow_flag,
  // Pins, asynchronous to clock
  input  wire logic       external_interrupt_in_a,
  input  wire logic       external_interrupt_in_b,
  input  wire logic       count_pin_a,
  input  wire logic       count_pin_b,
  // Pulse-width generator clocking
  output logic            timer1_overflow_strobe,
  output logic            pulse_width_clock_enable,
  // Clock output pin
  output logic            clock_output_pin,
  output logic            clock_output_oe
);

  logic       pre_tick;
  logic [7:0] clk_sel;
  logic [7:0] next_clk_sel;
  logic [7:0] next_rdata;
  logic       next_ovf_strobe;
  logic [7:0] count_low  [2];
  logic [7:0] count_high [2];
  logic [1:0] ovf;
  logic       split_ovf;
  logic [1:0] next_flag;
  // Pin synchronisers: stage 1, stage 2, edge history
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [1:0] cnt_hist;
  logic [1:0] cnt_fall;

  dtcs_prescaler u_prescaler (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tick    (pre_tick)
  );

  // Two flops on every pin, then edge history on the count pins
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pin_s1   <= 4'h0;
      pin_s2   <= 4'h0;
      cnt_hist <= 2'h0;
    end
    else
    begin
      pin_s1   <= {count_pin_b, count_pin_a, external_interrupt_in_b, external_interrupt_in_a};
      pin_s2   <= pin_s1;
      cnt_hist <= pin_s2[3:2];
    end
  end

  assign cnt_fall = cnt_hist & ~pin_s2[3:2];

  // Per-timer counting logic
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_timer
      localparam logic [7:0] ADDR_LOW  = (i == 0) ? dtcs_pkg::ADDR_T0_LOW
                                                  : dtcs_pkg::ADDR_T1_LOW;
      localparam logic [7:0] ADDR_HIGH = (i == 0) ? dtcs_pkg::ADDR_T0_HIGH
                                                  : dtcs_pkg::ADDR_T1_HIGH;
      localparam int FAST_BIT = (i == 0) ? dtcs_pkg::BIT_T0_FAST : dtcs_pkg::BIT_T1_FAST;

      logic [3:0]          ctl;
      dtcs_pkg::dtcs_mode_t mode;
      logic                run;
      logic                time_tick;
      logic                tick;
      logic                enable;
      logic                high_enable;
      logic [12:0]         sum13;
      logic [15:0]         sum16;
      logic [7:0]          next_low;
      logic [7:0]          next_high;
      logic                next_ovf;
      logic                next_split;

      assign ctl  = timer_mode_register[i*dtcs_pkg::MODE_NIBBLE +: dtcs_pkg::MODE_NIBBLE];
      assign mode = dtcs_pkg::dtcs_mode_t'(ctl[1:0]);
      assign run  = ((i == 0) ? timer0_run : timer1_run)
                    && (!ctl[dtcs_pkg::BIT_GATE] || pin_s2[i]);
      // Fast bit picks every clock over the prescaler pulse
      assign time_tick = clk_sel[FAST_BIT] ? 1'b1 : pre_tick;
      assign tick   = ctl[dtcs_pkg::BIT_CNT_SEL] ? cnt_fall[i] : time_tick;
      assign enable = run && tick && !(i == 1 && mode == dtcs_pkg::DTCS_MODE_SPLIT);
      // Split high half runs from timer 1's run bit and timer 0's time base
      assign high_enable = (i == 0) && (mode == dtcs_pkg::DTCS_MODE_SPLIT)
                           && timer1_run && time_tick;
      assign sum13 = 13'({count_high[i], count_low[i][4:0]} + 13'h0001);
      assign sum16 = 16'({count_high[i], count_low[i]} + 16'h0001);

      always_comb
      begin
        next_low   = count_low[i];
        next_high  = count_high[i];
        next_ovf   = 1'b0;
        next_split = 1'b0;
        if (enable)
        begin
          case (mode)
            dtcs_pkg::DTCS_MODE_13BIT:
            begin
              next_low  = {count_low[i][7:5], sum13[4:0]};
              next_high = sum13[12:5];
              next_ovf  = (sum13 == 13'h0000);
            end
            dtcs_pkg::DTCS_MODE_16BIT:
            begin
              {next_high, next_low} = sum16;
              next_ovf  = (sum16 == 16'h0000);
            end
            dtcs_pkg::DTCS_MODE_RELOAD:
            begin
              next_ovf = (count_low[i] == 8'hFF);
              next_low = next_ovf ? count_high[i] : 8'(count_low[i] + 8'h01);
            end
            dtcs_pkg::DTCS_MODE_SPLIT:
            begin
              next_low = 8'(count_low[i] + 8'h01);
              next_ovf = (count_low[i] == 8'hFF);
            end
            default:
            begin
              next_low = count_low[i];
            end
          endcase
        end
        if (high_enable)
        begin
          next_high  = 8'(count_high[i] + 8'h01);
          next_split = (count_high[i] == 8'hFF);
        end
        // Software write overrides the increment of that byte
        if (sfr_wr && sfr_addr == ADDR_LOW)
        begin
          next_low = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == ADDR_HIGH)
        begin
          next_high = sfr_wdata;
        end
      end

      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          count_low[i]  <= dtcs_pkg::RESET_BYTE;
          count_high[i] <= dtcs_pkg::RESET_BYTE;
          ovf[i]        <= 1'b0;
        end
        else
        begin
          count_low[i]  <= next_low;
          count_high[i] <= next_high;
          ovf[i]        <= next_ovf;
        end
      end

      if (i == 0)
      begin : g_split
        always_ff @(posedge clock)
        begin
          if (sys_rst)
          begin
            split_ovf <= 1'b0;
          end
          else
          begin
            split_ovf <= next_split;
          end
        end
      end
    end
  endgenerate

  // Flags: hardware set beats interrupt entry and software writes
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      if (ovf[k] || (k == 1 && split_ovf))
      begin
        next_flag[k] = 1'b1;
      end
      else if (flag_wr[k])
      begin
        next_flag[k] = flag_wdata[k];
      end
      else if (isr_entry[k])
      begin
        next_flag[k] = 1'b0;
      end
      else
      begin
        next_flag[k] = overflow_flag[k];
      end
    end
  end

  // Clock select, read data and overflow strobe
  always_comb
  begin
    next_clk_sel = clk_sel;
    if (sfr_wr && sfr_addr == dtcs_pkg::ADDR_CLK_SEL)
    begin
      next_clk_sel = sfr_wdata & dtcs_pkg::CLK_SEL_MASK;          // Reserved bits stay zero
    end
    case (sfr_addr)
      dtcs_pkg::ADDR_T0_LOW:  next_rdata = count_low[0];
      dtcs_pkg::ADDR_T1_LOW:  next_rdata = count_low[1];
      dtcs_pkg::ADDR_T0_HIGH: next_rdata = count_high[0];
      dtcs_pkg::ADDR_T1_HIGH: next_rdata = count_high[1];
      dtcs_pkg::ADDR_CLK_SEL: next_rdata = clk_sel;
      default:                next_rdata = 8'h00;
    endcase
    if (!sfr_rd)
    begin
      next_rdata = sfr_rdata;
    end
    next_ovf_strobe = ovf[1];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      clk_sel                <= dtcs_pkg::RESET_BYTE;
      sfr_rdata              <= 8'h00;
      overflow_flag          <= 2'h0;
      timer1_overflow_strobe <= 1'b0;
    end
    else
    begin
      clk_sel                <= next_clk_sel;
      sfr_rdata              <= next_rdata;
      overflow_flag          <= next_flag;
      timer1_overflow_strobe <= next_ovf_strobe;
    end
  end

  // Pulse-width enable: every cycle, or only on timer 1 overflow
  assign pulse_width_clock_enable = clk_sel[dtcs_pkg::BIT_PWM_SRC]
                                    ? timer1_overflow_strobe : 1'b1;

  // Gated clock out; enable changes at the rising edge, so a toggle may clip one pulse
  assign clock_output_oe  = clk_sel[dtcs_pkg::BIT_CLK_OUT];
  assign clock_output_pin = clock & clk_sel[dtcs_pkg::BIT_CLK_OUT];

endmodule // dtcs_timers

`default_nettype wire

// File: rtl/dtcs_pkg.sv
// Shared constants for the dual timer and clock select block
package dtcs_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_T0_LOW  = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW  = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CLK_SEL = 8'h8E;

  // Reset values
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // Clock select field positions
  localparam int BIT_PWM_SRC  = 6;
  localparam int BIT_T1_FAST  = 4;
  localparam int BIT_T0_FAST  = 3;
  localparam int BIT_CLK_OUT  = 1;
  localparam logic [7:0] CLK_SEL_MASK = 8'h5A;

  // Mode field layout, per timer nibble: gate, counter select, mode[1:0]
  localparam int MODE_NIBBLE  = 4;
  localparam int BIT_GATE     = 3;
  localparam int BIT_CNT_SEL  = 2;

  // Prescaler
  localparam int          PRESCALE_DIV  = 12;
  localparam logic [3:0]  PRESCALE_LAST = 4'(PRESCALE_DIV - 1);

  typedef enum logic [1:0] {
    DTCS_MODE_13BIT,
    DTCS_MODE_16BIT,
    DTCS_MODE_RELOAD,
    DTCS_MODE_SPLIT
  } dtcs_mode_t;

endpackage

// File: rtl/dtcs_prescaler.sv
`timescale 1ns/1ns
`default_nettype none

// Free-running divide-by-twelve enable source
module dtcs_prescaler (
  input  wire logic clock,
  input  wire logic sys_rst,
  output logic      tick
);

  logic [3:0] count;
  logic [3:0] next_count;
  logic       next_tick;

  // Wrap at the last step and flag it for one cycle
  always_comb
  begin
    next_tick  = (count == dtcs_pkg::PRESCALE_LAST);
    next_count = next_tick ? 4'h0 : 4'(count + 4'h1);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      count <= 4'h0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule // dtcs_prescaler

`default_nettype wire

// File: bench/dtcs_checker.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks for the timer block
module dtcs_checker (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic       timer0_run,
  input  wire logic       timer1_run,
  input  wire logic [1:0] flag_wr,
  input  wire logic [1:0] flag_wdata,
  input  wire logic [1:0] isr_entry,
  input  wire logic [1:0] overflow_flag,
  input  wire logic       timer1_overflow_strobe,
  input  wire logic       pulse_width_clock_enable,
  input  wire logic       clock_output_pin,
  input  wire logic       clock_output_oe
);
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic       cnt_a;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Shadow of clock select, rebuilt from bus writes since it is not a port
  always_comb
  begin
    next_sh = sh;
    if (sfr_wr && sfr_addr == dtcs_pkg::ADDR_CLK_SEL)
      next_sh = sfr_wdata & dtcs_pkg::CLK_SEL_MASK;
    if (sys_rst)
      next_sh = 8'h00;
  end
  always_ff @(posedge clock) sh <= next_sh;
  // Count byte addresses
  assign cnt_a = sfr_addr >= 8'h8A && sfr_addr <= 8'h8D;
  ck_readback_a: assert property (sfr_rd && sfr_addr == 8'h8E |=> sfr_rdata == $past(sh))
    else $error("clock select readback wrong");
  hole_zero_a: assert property (sfr_rd && !cnt_a && sfr_addr != 8'h8E |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_holds_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  count_back_a: assert property (sfr_wr && cnt_a ##1 sfr_rd && sfr_addr == $past(sfr_addr)
    && !timer0_run && !timer1_run |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("count byte readback wrong");
  clk_out_a: assert property (clock_output_oe == sh[1] && (clock_output_oe || !clock_output_pin))
    else $error("clock output enable wrong");
  pwm_sys_a: assert property (!sh[6] |-> pulse_width_clock_enable)
    else $error("pulse width clock not system clock");
  pwm_ovf_a: assert property (sh[6] |-> pulse_width_clock_enable == timer1_overflow_strobe)
    else $error("pulse width clock not overflow strobe");
  // Strobe and flag are set at the same edge from the same overflow pulse
  strobe_flag_a: assert property (timer1_overflow_strobe |-> overflow_flag[1])
    else $error("strobe without overflow");
  flag_sticky_a: assert property (overflow_flag[0] && !flag_wr[0] && !isr_entry[0]
    |=> overflow_flag[0])
    else $error("overflow flag dropped");
  // A wrap one cycle earlier may still set the flag, so both cycles must be idle
  isr_clear_a: assert property (isr_entry[0] && !flag_wr[0] && !timer0_run && !$past(timer0_run)
    |=> !overflow_flag[0])
    else $error("interrupt entry did not clear flag");
  sw_set_a: assert property (flag_wr[1] && flag_wdata[1] |=> overflow_flag[1])
    else $error("software flag set lost");
  cover property (timer1_overflow_strobe);
  cover property (isr_entry[0] && overflow_flag[0]);
  cover property (clock_output_oe);
endmodule // dtcs_checker

bind dtcs_timers dtcs_checker dtcs_checker_i (.clock, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .timer0_run, .timer1_run, .flag_wr, .flag_wdata, .isr_entry,
  .overflow_flag, .timer1_overflow_strobe, .pulse_width_clock_enable, .clock_output_pin,
  .clock_output_oe);
`default_nettype wire

// File: bench/dtcs_timers_tb.sv
`timescale 1ns/1ns
`default_nettype none
// Register-level tests of the timer block
module dtcs_timers_tb;
  logic       clock = '0;
  logic       sys_rst = '1;
  logic [7:0] sfr_addr = '0;
  logic       sfr_wr = '0;
  logic       sfr_rd = '0;
  logic [7:0] sfr_wdata = '0;
  logic [7:0] sfr_rdata;
  logic [7:0] mode = '0;
  logic       run0 = '0;
  logic       run1 = '0;
  logic [1:0] fwr = '0;
  logic [1:0] fwd = '0;
  logic [1:0] isr = '0;
  logic [1:0] flag;
  logic       eia = '0;
  logic       cpa = '0;
  logic       stb;
  logic       pwe;
  logic       oe;
  int         failures = 0;
  int         compares = 0;
  int         strobes = 0;

  dtcs_timers dtcs_timers_i (
    .clock, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .timer_mode_register(mode), .timer0_run(run0), .timer1_run(run1),
    .flag_wr(fwr), .flag_wdata(fwd), .isr_entry(isr), .overflow_flag(flag),
    .external_interrupt_in_a(eia), .external_interrupt_in_b(1'h1),
    .count_pin_a(cpa), .count_pin_b(1'h1), .timer1_overflow_strobe(stb),
    .pulse_width_clock_enable(pwe), .clock_output_pin(), .clock_output_oe(oe));

  // Clock and overflow strobe tally
  initial
  begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) if (stb === 1'h1) strobes++;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes stay up between calls so accesses can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    sfr_rd = 1'h0;
    @(posedge clock) #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    sfr_addr = a;
    sfr_wr = 1'h0;
    sfr_rd = 1'h1;
    @(posedge clock) #1;
    chk(sfr_rdata & m, e);
  endtask
  // Run a timer for exactly k clock edges
  task automatic run(input bit t, input int k);
    sfr_wr = 1'h0;
    sfr_rd = 1'h0;
    if (t) run1 = 1'h1; else run0 = 1'h1;
    repeat (k) @(posedge clock);
    #1 run0 = 1'h0;
    run1 = 1'h0;
  endtask
  task automatic pf(input logic [1:0] w, input logic [1:0] d, input logic [1:0] i,
                    input logic [1:0] e);
    sfr_wr = 1'h0;
    sfr_rd = 1'h0;
    fwr = w;
    fwd = d;
    isr = i;
    @(posedge clock) #1 fwr = 2'h0;
    isr = 2'h0;
    chk({6'h00, flag}, {6'h00, e});
  endtask
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog, far beyond the expected run of under a thousand cycles
  initial
  begin
    #100000 failures++;
    summarize();
  end

  // Test sequence
  initial
  begin
    repeat (12) @(posedge clock);
    #1 sys_rst = 1'h0;
    for (int a = 8'h8A; a <= 8'h8F; a++) rd(8'(a), 8'h00);
    chk({6'h00, oe, pwe}, 8'h01);
    for (int a = 8'h8A; a <= 8'h8D; a++)
    begin
      wr(8'(a), 8'(a) ^ 8'hA5);
      rd(8'(a), 8'(a) ^ 8'hA5);
    end
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'h5A);
    chk({7'h00, oe}, 8'h01);
    wr(8'h8F, 8'h77);
    rd(8'h8F, 8'h00);
    // Timer 0 on the fast clock, 16-bit wrap
    wr(8'h8E, 8'h08);
    mode = 8'h01;
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFF);
    run(0, 5);
    rd(8'h8A, 8'h03);
    rd(8'h8C, 8'h00);
    chk({6'h00, flag}, 8'h01);
    // 13-bit mode, upper low-byte bits ignored
    mode = 8'h00;
    wr(8'h8A, 8'h1E);
    wr(8'h8C, 8'hFF);
    run(0, 3);
    rd(8'h8A, 8'h01, 8'h1F);
    rd(8'h8C, 8'h00);
    pf(2'h1, 2'h0, 2'h0, 2'h0);
    // Gate holds the count until the interrupt input is high
    mode = 8'h09;
    wr(8'h8A, 8'h00);
    run(0, 6);
    rd(8'h8A, 8'h00);
    // Two sync flops swallow the first two of twelve edges
    eia = 1'h1;
    run(0, 12);
    rd(8'h8A, 8'h0A);
    // Counter select counts falling edges of the pin
    mode = 8'h04;
    wr(8'h8A, 8'h00);
    sfr_wr = 1'h0;
    run0 = 1'h1;
    repeat (3)
    begin
      cpa = 1'h1;
      repeat (4) @(posedge clock);
      #1 cpa = 1'h0;
      repeat (4) @(posedge clock);
      #1;
    end
    run(0, 6);
    rd(8'h8A, 8'h03);
    // Timer 1 on the divided clock: 24 edges hold two ticks
    wr(8'h8E, 8'h40);
    mode = 8'h10;
    wr(8'h8B, 8'hFF);
    wr(8'h8D, 8'hFF);
    run(1, 24);
    rd(8'h8B, 8'h01);
    rd(8'h8D, 8'h00);
    chk(8'(strobes), 8'h01);
    chk({6'h00, flag}, 8'h02);
    // Auto-reload from the high byte, then halt in mode 3
    wr(8'h8E, 8'h10);
    mode = 8'h20;
    wr(8'h8D, 8'hF0);
    wr(8'h8B, 8'hFE);
    run(1, 3);
    rd(8'h8B, 8'hF1);
    rd(8'h8D, 8'hF0);
    mode = 8'h30;
    wr(8'h8B, 8'h10);
    run(1, 4);
    rd(8'h8B, 8'h10);
    rd(8'h8B, 8'h10);
    // Flag writes and interrupt entry
    pf(2'h2, 2'h0, 2'h0, 2'h0);
    pf(2'h3, 2'h3, 2'h0, 2'h3);
    pf(2'h0, 2'h0, 2'h1, 2'h2);
    // Timer 0 split: high byte runs on timer 1's run bit, wraps into flag 1
    pf(2'h2, 2'h0, 2'h0, 2'h0);
    wr(8'h8E, 8'h08);
    mode = 8'h03;
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'hFF);
    run(1, 2);
    rd(8'h8C, 8'h01);
    rd(8'h8A, 8'h00);
    chk({6'h00, flag}, 8'h02);
    summarize();
  end
endmodule // dtcs_timers_tb
`default_nettype wire
